// >>> bench/tb_timer_clock_clear_select.sv
// self-checking bench: channel 0 plus a narrow channel on one bus
// assumes tcc_channel, tcc_pins_model and tcc_channel_props compiled
`timescale 1ns/1ps
`default_nettype none
module tb_timer_clock_clear_select;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic [3:0] mt = 4'h0;
  logic [1:0] bufs = 2'h0;
  logic sy = 1'b0;
  wire logic [3:0] pins;
  wire logic [7:0] rd0;
  wire logic [7:0] rd1;
  wire logic [15:0] cnt;
  wire logic so;
  wire logic ov;
  int ovs = 0;
  logic [7:0] q0;
  logic [7:0] q1;
  int seed = 46849;
  int miscompares = 0;
  int samples_checked = 0;
  tcc_pins_model PINS (.clk_in, .pins_out(pins));
  tcc_channel #(.CHANNEL(0)) DUT (.clk_in, .rst_b_in, .addr_in, .wdata_in,
    .write_in, .read_in, .rdata_out(rd0), .ext_clock_pin_a_in(pins[0]),
    .ext_clock_pin_b_in(pins[1]), .ext_clock_pin_c_in(pins[2]),
    .ext_clock_pin_d_in(pins[3]), .cascade_tick_in(1'b0),
    .match_a_in(mt[0]), .match_b_in(mt[1]), .match_c_in(mt[2]),
    .match_d_in(mt[3]), .buffer_c_in(bufs[0]), .buffer_d_in(bufs[1]),
    .sync_clear_in(sy), .sync_clear_out(so), .overflow_out(ov),
    .channel_counter_out(cnt));
  tcc_channel #(.CHANNEL(1)) DUT_N (.clk_in, .rst_b_in, .addr_in,
    .wdata_in, .write_in, .read_in, .rdata_out(rd1),
    .ext_clock_pin_a_in(pins[0]), .ext_clock_pin_b_in(pins[1]),
    .ext_clock_pin_c_in(pins[2]), .ext_clock_pin_d_in(pins[3]),
    .cascade_tick_in(so), .match_a_in(mt[0]), .match_b_in(mt[1]),
    .match_c_in(mt[2]), .match_d_in(mt[3]), .buffer_c_in(bufs[0]),
    .buffer_d_in(bufs[1]), .sync_clear_in(so), .sync_clear_out(),
    .overflow_out(), .channel_counter_out());
  always #10 clk_in = ~clk_in;
  // overflow pulses of the wide channel, looked at mid-cycle
  always @(negedge clk_in) begin
    if (ov === 1'b1) begin
      ovs++;
    end
  end
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clk_in);
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clk_in);
    read_in <= 1'b0;
    #1;
    q0 = rd0;
    q1 = rd1;
    @(posedge clk_in);
  endtask
  task automatic rd_cnt(output logic [15:0] v, output logic [15:0] w);
    rd(4'h2);
    v[7:0] = q0;
    w[7:0] = q1;
    rd(4'h3);
    v[15:8] = q0;
    w[15:8] = q1;
  endtask
  function automatic logic clears(input logic [7:0] c, input int m,
    input logic [1:0] b, input logic s);
    case (c[6:5])
      2'h1: return c[7] ? (m == 2 && !b[0]) : m == 0;
      2'h2: return c[7] ? (m == 3 && !b[1]) : m == 1;
      2'h3: return m == 4 && s;
      default: return 1'b0;
    endcase
  endfunction
  task automatic final_report;
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (90000) @(posedge clk_in);
    miscompares++;
    final_report();
  end
  // main sequence
  initial begin
    logic [15:0] v0;
    logic [15:0] v1;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] x;
    logic [7:0] c;
    logic [1:0] b;
    logic s;
    int m;
    int n;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      c = 8'($random(seed));
      wr(4'h0, c);
      rd(4'h0);
      check("ctrl", q0, c);
      check("ctrl narrow", q1, c & 8'h7F);
    end
    rd(4'hF);
    check("unmapped", q0, 16'h0000);
    // internal taps over a 64-edge run window, every edge code
    for (int p = 0; p < 4; p++) begin
      for (int e = 0; e < 4; e++) begin
        wr(4'h0, 8'(e * 8 + p));
        rd_cnt(v0, w0);
        wr(4'h1, 8'h02);
        repeat (62) @(posedge clk_in);
        wr(4'h1, 8'h00);
        rd_cnt(v1, w1);
        x = 16'(p == 0 ? 64 : (64 >> 2 * p) << e / 2);
        check("tap", v1 - v0, x);
        check("tap narrow", w1 - w0, x);
      end
    end
    // external pins A to D, edge code follows the pin index
    for (int p = 0; p < 4; p++) begin
      n = 1 + ($random(seed) & 3);
      wr(4'h0, 8'(p * 8 + 4 + p));
      rd_cnt(v0, w0);
      wr(4'h1, 8'h02);
      PINS.burst(p, n);
      repeat (6) @(posedge clk_in);
      wr(4'h1, 8'h00);
      rd_cnt(v1, w1);
      check("pin", v1 - v0, 16'(p > 1 ? 2 * n : n));
    end
    // narrow channel on /256 while the wide channel watches idle pin C
    wr(4'h0, 8'h06);
    rd_cnt(v0, w0);
    wr(4'h1, 8'h02);
    repeat (510) @(posedge clk_in);
    wr(4'h1, 8'h00);
    rd_cnt(v1, w1);
    check("div256", w1 - w0, 16'h0002);
    check("idle pin", v1 - v0, 16'h0000);
    // one full lap of the counter: same value back, one overflow pulse
    wr(4'h0, 8'h00);
    rd_cnt(v0, w0);
    n = ovs;
    wr(4'h1, 8'h02);
    repeat (65534) @(posedge clk_in);
    wr(4'h1, 8'h00);
    rd_cnt(v1, w1);
    check("wrap", v1, v0);
    check("overflow", 16'(ovs - n), 16'h0001);
    // clear source against match, buffer level and sync bit
    for (int i = 0; i < 32; i++) begin
      c = 8'($random(seed)) & 8'hE0;
      m = {$random(seed)} % 5;
      b = 2'($random(seed));
      s = 1'($random(seed));
      if (i == 0) begin
        c = 8'hA0;
        m = 2;
        b = 2'h1;
      end
      bufs <= b;
      wr(4'h0, c);
      wr(4'h1, {6'h00, 1'b1, s});
      repeat (5) @(posedge clk_in);
      wr(4'h1, {6'h00, 1'b0, s});
      rd_cnt(v0, w0);
      if (m < 4) mt[m] <= 1'b1;
      else sy <= 1'b1;
      @(posedge clk_in);
      mt <= 4'h0;
      sy <= 1'b0;
      @(posedge clk_in);
      rd_cnt(v1, w1);
      x = clears(c, m, b, s) ? 16'h0000 : v0;
      check("clear", v1, x);
    end
    final_report();
  end
endmodule
bind tcc_channel tcc_channel_props #(.CHANNEL(CHANNEL),
  .COUNT_WIDTH(COUNT_WIDTH)) u_props (.clk_in, .rst_b_in, .addr_in,
  .wdata_in, .write_in, .read_in, .rdata_out, .match_a_in, .match_b_in,
  .match_c_in, .match_d_in, .buffer_c_in, .buffer_d_in, .sync_clear_in,
  .sync_clear_out, .overflow_out, .channel_counter_out);
`default_nettype wire

// >>> bench/tcc_channel_props.sv
// checker for one timer channel: clear, count and readback relations
// assumes bind to tcc_channel; register shadows follow the write port
`timescale 1ns/1ps
`default_nettype none
module tcc_channel_props #(
  parameter int CHANNEL = 0,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic match_a_in,
  input wire logic match_b_in,
  input wire logic match_c_in,
  input wire logic match_d_in,
  input wire logic buffer_c_in,
  input wire logic buffer_d_in,
  input wire logic sync_clear_in,
  input wire logic sync_clear_out,
  input wire logic overflow_out,
  input wire logic [COUNT_WIDTH-1:0] channel_counter_out
);
  logic [7:0] ctrl;
  logic [7:0] ls;
  logic evt;
  logic syn;
  logic quiet;
  // shadows of control and lockstep
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= 8'h00;
      ls <= 8'h00;
    end else if (write_in && addr_in == 4'h0) begin
      ctrl <= (CHANNEL % 3 == 0) ? wdata_in : wdata_in & 8'h7F;
    end else if (write_in && addr_in == 4'h1) begin
      ls <= wdata_in & 8'h03;
    end
  end
  // selected clear events
  assign evt = (ctrl[6:5] == 2'h1 &&
    (ctrl[7] ? match_c_in && !buffer_c_in : match_a_in)) ||
    (ctrl[6:5] == 2'h2 &&
    (ctrl[7] ? match_d_in && !buffer_d_in : match_b_in));
  assign syn = ctrl[6:5] == 2'h3 && sync_clear_in && ls[0];
  assign quiet = !evt && !syn && !write_in;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_run;
    ls[1] && ctrl[2:0] == 3'h0 && quiet;
  endsequence
  sequence s_stop;
    !ls[1] && quiet;
  endsequence
  a_read_idle: assert property (!read_in |=> rdata_out == 8'h00)
    else $error("read data not zero");
  a_ctrl_read: assert property (
    read_in && addr_in == 4'h0 |=> rdata_out == ctrl)
    else $error("control readback wrong");
  a_lock_read: assert property (
    read_in && addr_in == 4'h1 |=> rdata_out == ls)
    else $error("lockstep readback wrong");
  a_clear_zero: assert property (
    evt || syn |-> ##2 channel_counter_out == '0)
    else $error("counter not cleared");
  a_sync_pulse: assert property (ls[0] && evt |=> sync_clear_out)
    else $error("sync clear missing");
  a_sync_quiet: assert property (
    !(ls[0] && evt) |=> !sync_clear_out)
    else $error("stray sync clear");
  a_count_run: assert property (
    s_run ##1 s_run |=>
    channel_counter_out == $past(channel_counter_out) + 1'b1)
    else $error("counter did not advance");
  a_wrap_pulse: assert property (
    overflow_out |-> channel_counter_out == '1)
    else $error("overflow without wrap");
  a_stop_hold: assert property (
    s_stop ##1 s_stop |=> $stable(channel_counter_out))
    else $error("counter moved while stopped");
endmodule
`default_nettype wire

// >>> bench/tcc_pins_model.sv
// external clock pins driven as square pulses
// assumes the caller starts a burst just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
  input wire logic clk_in,
  output logic [3:0] pins_out
);
  initial pins_out = 4'h0;
  // high held 3 cycles and low 4 between pulses, so the pin synchroniser sees each level
  task automatic burst(input int pin, input int n);
    repeat (n) begin
      @(posedge clk_in);
      pins_out[pin] <= 1'b1;
      repeat (3) @(posedge clk_in);
      pins_out[pin] <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// >>> rtl/tcc_cfg.svh
// tcc_cfg.svh: offsets, field positions, reset values and timing counts
// for one channel of the multi-channel timer clock and clear select logic.
// assumes inclusion by bare name from files under rtl/.
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// register offsets on the plain register port
`define TCC_OFS_CONTROL 4'h0
`define TCC_OFS_LOCKSTEP 4'h1
`define TCC_OFS_COUNT_LO 4'h2
`define TCC_OFS_COUNT_HI 4'h3

// control register fields
`define TCC_CLR_HI 7
`define TCC_CLR_LO_MSB 6
`define TCC_CLR_LO_LSB 5
`define TCC_EDGE_MSB 4
`define TCC_EDGE_LSB 3
`define TCC_PSC_MSB 2
`define TCC_PSC_LSB 0
`define TCC_CTRL_RESET 8'h00
`define TCC_CTRL_MASK_NARROW 8'h7F

// lockstep register fields
`define TCC_LS_SYNC 0
`define TCC_LS_RUN 1
`define TCC_LS_MASK 8'h03
`define TCC_LS_RESET 8'h00

// clock edge codes
`define TCC_EDGE_RISE 2'h0
`define TCC_EDGE_FALL 2'h1

// prescaler taps: the bit of the free divider that toggles at each rate
`define TCC_TAP_DIV4 1
`define TCC_TAP_DIV16 3
`define TCC_TAP_DIV64 5
`define TCC_TAP_DIV256 7
`define TCC_DIV_WIDTH 8

`endif

// >>> rtl/tcc_channel.sv
// tcc_channel: clock select, edge select and clear select of one timer
// channel, with its counter and control registers on a plain port.
// assumes match/capture pulses and buffer-mode levels come from the
// general register logic on clk_in; external clock pins are asynchronous.
//
// Contract
// RULE1: edge code 00 counts rising, 01 falling, upper bit 1 both edges.
// RULE2: prescale field bits 2..0 pick the clock, each channel on its own.
// RULE3: channels 0,3 with bit7 low: none, A, B, or synchronous clear.
// RULE4: channels 0,3 with bit7 high: none, C, D, or synchronous clear.
// RULE5: no clearing on C or D while that register is a buffer.
// RULE6: synchronous clearing only when the channel's sync bit is set.
// RULE7: channels 1,2,4,5 bit 7 reads zero and ignores writes.
// RULE8: channels 1,2,4,5 bits 6,5: none, A, B, or synchronous clear.
// RULE9: channel 0 codes 100..111 count external pins A, B, C, D.
// RULE10: edge select only for divide-by-4 or slower, not /1 or cascade.
// RULE11: software writes the control register only while stopped.
// RULE12: counter zero the cycle after a clear event, else counts edges.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_channel #(
  parameter int CHANNEL = 0,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  input wire logic ext_clock_pin_a_in,
  input wire logic ext_clock_pin_b_in,
  input wire logic ext_clock_pin_c_in,
  input wire logic ext_clock_pin_d_in,
  input wire logic cascade_tick_in,
  input wire logic match_a_in,
  input wire logic match_b_in,
  input wire logic match_c_in,
  input wire logic match_d_in,
  input wire logic buffer_c_in,
  input wire logic buffer_d_in,
  input wire logic sync_clear_in,
  output logic sync_clear_out,
  output logic overflow_out,
  output logic [COUNT_WIDTH-1:0] channel_counter_out
);

  localparam bit WIDE = (CHANNEL == 0) || (CHANNEL == 3);

  logic [7:0] timer_channel_control;
  logic [7:0] lockstep_control;
  logic [COUNT_WIDTH-1:0] channel_counter;
  logic [`TCC_DIV_WIDTH-1:0] divider;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_last;
  logic div_last;
  tcc_pkg::tcc_src_t next_src;
  tcc_pkg::tcc_clr_t next_clr;
  logic next_level;
  logic next_prev;
  logic next_tick;
  logic next_clear;
  logic own_event;

  // edge qualifier shared by divided and external clock levels
  function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                    input logic was);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    if (sel[1]) begin
      edge_hit = rise | fall; // RULE1
    end else if (sel == `TCC_EDGE_FALL) begin
      edge_hit = fall; // RULE1
    end else begin
      edge_hit = rise; // RULE1
    end
  endfunction

  // register writes; software keeps them to stopped periods
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_channel_control <= `TCC_CTRL_RESET;
    end else if (write_in && addr_in == `TCC_OFS_CONTROL) begin
      if (WIDE) begin
        timer_channel_control <= wdata_in;
      end else begin
        timer_channel_control <= wdata_in & `TCC_CTRL_MASK_NARROW; // RULE7
      end
    end
  end

  // lockstep register: sync enable and counter run
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lockstep_control <= `TCC_LS_RESET;
    end else if (write_in && addr_in == `TCC_OFS_LOCKSTEP) begin
      lockstep_control <= wdata_in & `TCC_LS_MASK;
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
    end else if (read_in) begin
      case (addr_in)
        `TCC_OFS_CONTROL: rdata_out <= timer_channel_control;
        `TCC_OFS_LOCKSTEP: rdata_out <= lockstep_control;
        `TCC_OFS_COUNT_LO: rdata_out <= channel_counter[7:0];
        `TCC_OFS_COUNT_HI: rdata_out <= channel_counter[15:8];
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // free-running divider feeding the internal prescaled rates
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      divider <= '0;
    end else begin
      divider <= divider + `TCC_DIV_WIDTH'(1);
    end
  end

  // two-stage synchronisers for the external clock pins
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_last <= 4'h0;
    end else begin
      pin_meta <= {ext_clock_pin_d_in, ext_clock_pin_c_in,
                   ext_clock_pin_b_in, ext_clock_pin_a_in};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // decode the prescale field into a source and a level to watch
  always_comb begin
    next_src = tcc_pkg::TCC_SRC_DIV1;
    next_level = 1'b0;
    next_prev = 1'b0;
    case (timer_channel_control[`TCC_PSC_MSB:`TCC_PSC_LSB]) // RULE2
      3'h0: next_src = tcc_pkg::TCC_SRC_DIV1;
      3'h1: begin
        next_src = tcc_pkg::TCC_SRC_DIV;
        next_level = divider[`TCC_TAP_DIV4];
      end
      3'h2: begin
        next_src = tcc_pkg::TCC_SRC_DIV;
        next_level = divider[`TCC_TAP_DIV16];
      end
      3'h3: begin
        next_src = tcc_pkg::TCC_SRC_DIV;
        next_level = divider[`TCC_TAP_DIV64];
      end
      3'h4: begin
        next_src = tcc_pkg::TCC_SRC_EXT; // RULE9
        next_level = pin_sync[0];
        next_prev = pin_last[0];
      end
      3'h5: begin
        next_src = tcc_pkg::TCC_SRC_EXT; // RULE9
        next_level = pin_sync[1];
        next_prev = pin_last[1];
      end
      3'h6: begin
        if (CHANNEL == 0) begin
          next_src = tcc_pkg::TCC_SRC_EXT; // RULE9
          next_level = pin_sync[2];
          next_prev = pin_last[2];
        end else begin
          next_src = tcc_pkg::TCC_SRC_DIV;
          next_level = divider[`TCC_TAP_DIV256];
        end
      end
      3'h7: begin
        if (CHANNEL == 0) begin
          next_src = tcc_pkg::TCC_SRC_EXT; // RULE9
          next_level = pin_sync[3];
          next_prev = pin_last[3];
        end else begin
          next_src = tcc_pkg::TCC_SRC_CASCADE;
        end
      end
      default: next_src = tcc_pkg::TCC_SRC_DIV1;
    endcase
  end

  // remember the divided level so its edges can be found
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_last <= 1'b0;
    end else begin
      div_last <= next_level;
    end
  end

  // qualified count tick from the selected source
  always_comb begin
    case (next_src)
      tcc_pkg::TCC_SRC_DIV1: next_tick = 1'b1; // RULE10
      tcc_pkg::TCC_SRC_CASCADE: next_tick = cascade_tick_in; // RULE10
      tcc_pkg::TCC_SRC_DIV: next_tick = edge_hit(
        timer_channel_control[`TCC_EDGE_MSB:`TCC_EDGE_LSB],
        next_level, div_last); // RULE10
      tcc_pkg::TCC_SRC_EXT: next_tick = edge_hit(
        timer_channel_control[`TCC_EDGE_MSB:`TCC_EDGE_LSB],
        next_level, next_prev);
      default: next_tick = 1'b0;
    endcase
  end

  // decode the clear select field per channel width
  always_comb begin
    next_clr = tcc_pkg::TCC_CLR_NONE;
    case (timer_channel_control[`TCC_CLR_LO_MSB:`TCC_CLR_LO_LSB])
      2'h1: begin
        if (WIDE && timer_channel_control[`TCC_CLR_HI]) begin
          next_clr = tcc_pkg::TCC_CLR_C; // RULE4
        end else begin
          next_clr = tcc_pkg::TCC_CLR_A; // RULE3 RULE8
        end
      end
      2'h2: begin
        if (WIDE && timer_channel_control[`TCC_CLR_HI]) begin
          next_clr = tcc_pkg::TCC_CLR_D; // RULE4
        end else begin
          next_clr = tcc_pkg::TCC_CLR_B; // RULE3 RULE8
        end
      end
      2'h3: next_clr = tcc_pkg::TCC_CLR_SYNC; // RULE3 RULE4 RULE8
      default: next_clr = tcc_pkg::TCC_CLR_NONE;
    endcase
  end

  // clearing event from the selected source
  always_comb begin
    own_event = 1'b0;
    next_clear = 1'b0;
    case (next_clr)
      tcc_pkg::TCC_CLR_A: own_event = match_a_in;
      tcc_pkg::TCC_CLR_B: own_event = match_b_in;
      tcc_pkg::TCC_CLR_C: own_event = match_c_in & ~buffer_c_in; // RULE5
      tcc_pkg::TCC_CLR_D: own_event = match_d_in & ~buffer_d_in; // RULE5
      tcc_pkg::TCC_CLR_SYNC: next_clear =
        sync_clear_in & lockstep_control[`TCC_LS_SYNC]; // RULE6
      default: own_event = 1'b0;
    endcase
    next_clear = next_clear | own_event;
  end

  // counter: clear wins over counting, counting only while running
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      channel_counter <= '0;
      overflow_out <= 1'b0;
    end else begin
      overflow_out <= 1'b0;
      if (next_clear) begin
        channel_counter <= '0; // RULE12
      end else if (lockstep_control[`TCC_LS_RUN] && next_tick) begin
        channel_counter <= channel_counter + COUNT_WIDTH'(1); // RULE12
        overflow_out <= &channel_counter;
      end
    end
  end

  // tell synchronised channels that this one cleared on its own event
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_clear_out <= 1'b0;
    end else begin
      sync_clear_out <= own_event & lockstep_control[`TCC_LS_SYNC]; // RULE6
    end
  end

  // counter value for the general register logic
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      channel_counter_out <= '0;
    end else begin
      channel_counter_out <= channel_counter;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/tcc_pkg.sv
// tcc_pkg: types shared by the timer clock and clear select logic.
// assumes the constants of tcc_cfg.svh for field positions.
package tcc_pkg;

  // source of the counter clock after decoding the prescale field
  typedef enum logic [2:0] {
    TCC_SRC_DIV1 = 3'h0,
    TCC_SRC_DIV = 3'h1,
    TCC_SRC_EXT = 3'h2,
    TCC_SRC_CASCADE = 3'h3
  } tcc_src_t;

  // source of the counter clearing event
  typedef enum logic [2:0] {
    TCC_CLR_NONE = 3'h0,
    TCC_CLR_A = 3'h1,
    TCC_CLR_B = 3'h2,
    TCC_CLR_C = 3'h3,
    TCC_CLR_D = 3'h4,
    TCC_CLR_SYNC = 3'h5
  } tcc_clr_t;

endpackage
